/* File: hdl/scs_pkg.sv */
// Shared constants for the sampling converter sequencer.
package scs_pkg;

  // ----------------------------------------------------------------
  // Register map and bus answers
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL        = 4'h0;
  localparam logic [3:0] ADDR_RESULT_HIGH = 4'h4;
  localparam logic [3:0] ADDR_RESULT_LOW  = 4'h8;
  localparam logic [3:0] ADDR_MASK        = 4'hC;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------
  // Field positions of the control register
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_REF_EXT_BIT  = 1;
  localparam int CTRL_CHANNEL_LSB  = 2;
  localparam int CTRL_COUNT_LSB    = 5;
  localparam int CTRL_EXT_TRIG_BIT = 8;
  localparam int CTRL_EDGE_BIT     = 9;
  localparam int CTRL_HOLDOFF_BIT  = 10;
  localparam int CTRL_DELAY_LSB    = 11;
  localparam int CTRL_WAIT_LSB     = 15;

  // Field positions of the high result register.
  localparam int RES_STATUS_BIT = 4;
  localparam int RES_SELECT_LSB = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [18:0] CTRL_RESET   = 19'h00000;
  localparam logic [1:0]  SELECT_RESET = 2'h0;
  localparam logic        MASK_RESET   = 1'b1;

  // ----------------------------------------------------------------
  // Timing: delay step in microseconds, clock cycles per microsecond
  // ----------------------------------------------------------------
  localparam int DELAY_STEP_US = 50;
  localparam int DEFAULT_CYCLES_PER_US = 50;

  // Result selections; plain sample mode presents the last sample.
  typedef enum logic [1:0] {
    SEL_AVERAGE = 2'b00,
    SEL_MINIMUM = 2'b01,
    SEL_MAXIMUM = 2'b10,
    SEL_LAST    = 2'b11
  } scs_select_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARM     = 3'b001,
    ST_DELAY   = 3'b010,
    ST_START   = 3'b011,
    ST_CONVERT = 3'b100,
    ST_WAIT    = 3'b101,
    ST_FINISH  = 3'b110
  } scs_state_t;

endpackage

/* File: hdl/scs_sequencer.sv */
// Converter sequencer with trigger control, result unit and AXI4-Lite registers.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int CYCLES_PER_US = scs_pkg::DEFAULT_CYCLES_PER_US
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        trigger_input_pin,
  input  wire logic [9:0]  conv_data,
  input  wire logic        conv_done,
  output logic             conv_start,
  output logic [2:0]       mux_select,
  output logic             ref_ext_select,
  output logic             ref_regulator_en,
  output logic             int_n
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [18:0]  ctrl;
  logic [1:0]   result_select;
  logic         int_mask;
  logic [3:0]   aw_addr;
  logic         aw_held;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         w_held;
  logic         enable_prev;
  logic         start_cycle;
  logic         cycle_busy;
  scs_state_t   state;
  logic [23:0]  timer;
  logic [8:0]   remaining;
  logic         trigger_seen;
  logic [2:0]   cfg_channel;
  logic         cfg_ref_ext;
  logic [2:0]   cfg_count;
  logic         cfg_ext;
  logic         cfg_edge;
  logic         cfg_holdoff;
  logic [3:0]   cfg_delay;
  logic [3:0]   cfg_wait;
  logic         trig_meta;
  logic         trig_sync;
  logic         trig_prev;
  logic         trig_match;
  logic         trig_active;
  logic         first_sample;
  logic [17:0]  sum;
  logic [9:0]   min_val;
  logic [9:0]   max_val;
  logic [9:0]   last_val;
  logic [10:0]  res_avg;
  logic [10:0]  res_min;
  logic [10:0]  res_max;
  logic [10:0]  res_last;
  logic [10:0]  accumulator;
  logic [31:0]  next_ctrl_word;

  // Sample count code: 0 gives one sample, code n gives 2^(n+1).
  function automatic logic [3:0] count_shift(input logic [2:0] code);
    count_shift = (code == 3'h0) ? 4'h0 : {1'b0, code} + 4'h1;
  endfunction

  // Wait time in microseconds for each code of the wait field.
  function automatic int wait_us(input logic [3:0] code);
    case (code)
      4'h0:    wait_us = 20;
      4'h1:    wait_us = 40;
      4'h2:    wait_us = 60;
      4'h3:    wait_us = 80;
      4'h4:    wait_us = 160;
      4'h5:    wait_us = 240;
      4'h6:    wait_us = 320;
      4'h7:    wait_us = 640;
      4'h8:    wait_us = 1280;
      4'h9:    wait_us = 1920;
      4'hA:    wait_us = 2560;
      4'hB:    wait_us = 5120;
      4'hC:    wait_us = 10240;
      4'hD:    wait_us = 15360;
      default: wait_us = 20480;
    endcase
  endfunction

  // Cycles still to count after the loading cycle of a delay or wait.
  function automatic logic [23:0] delay_cycles(input logic [3:0] code);
    delay_cycles = 24'(int'(code) * DELAY_STEP_US * CYCLES_PER_US);
  endfunction

  function automatic logic [23:0] wait_cycles(input logic [3:0] code);
    wait_cycles = 24'(wait_us(code) * CYCLES_PER_US);
  endfunction

  // Merge the written bytes into an old word under the strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_word, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = result;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are caught in either order; the answer follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_RESULT_HIGH ||
                         aw_addr == ADDR_RESULT_LOW || aw_addr == ADDR_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign next_ctrl_word = merge({13'h0000, ctrl}, w_data, w_strb);

  // Register stores; a write commits in the cycle the answer is raised.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl          <= CTRL_RESET;
      result_select <= SELECT_RESET;
      int_mask      <= MASK_RESET;
    end else if (aw_held && w_held && !s_axi_bvalid) begin
      if (aw_addr == ADDR_CTRL) begin
        ctrl <= next_ctrl_word[18:0];
      end else if (aw_addr == ADDR_RESULT_HIGH) begin
        if (!cycle_busy && w_strb[0]) begin
          result_select <= w_data[RES_SELECT_LSB +: 2];
        end
      end else if (aw_addr == ADDR_MASK) begin
        if (w_strb[0]) begin
          int_mask <= w_data[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // One read at a time; data is answered the cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == ADDR_CTRL) begin
          s_axi_rdata <= {13'h0000, ctrl};
        end else if (s_axi_araddr == ADDR_RESULT_HIGH) begin
          s_axi_rdata <= {25'h0000000, result_select, cycle_busy, 1'b0, accumulator[10:8]};
        end else if (s_axi_araddr == ADDR_RESULT_LOW) begin
          s_axi_rdata <= {24'h000000, accumulator[7:0]};
        end else if (s_axi_araddr == ADDR_MASK) begin
          s_axi_rdata <= {31'h00000000, int_mask};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cycle start and configuration latch
  // ----------------------------------------------------------------
  // start on rising enable
  assign start_cycle = ctrl[CTRL_ENABLE_BIT] && !enable_prev && state == ST_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_prev <= 1'b0;
      cfg_channel <= 3'h0;
      cfg_ref_ext <= 1'b0;
      cfg_count   <= 3'h0;
      cfg_ext     <= 1'b0;
      cfg_edge    <= 1'b0;
      cfg_holdoff <= 1'b0;
      cfg_delay   <= 4'h0;
      cfg_wait    <= 4'h0;
    end else begin
      enable_prev <= ctrl[CTRL_ENABLE_BIT];
      if (start_cycle) begin
        cfg_channel <= ctrl[CTRL_CHANNEL_LSB +: 3];
        cfg_ref_ext <= ctrl[CTRL_REF_EXT_BIT];
        cfg_count   <= ctrl[CTRL_COUNT_LSB +: 3];
        cfg_ext     <= ctrl[CTRL_EXT_TRIG_BIT];
        cfg_edge    <= ctrl[CTRL_EDGE_BIT];
        cfg_holdoff <= ctrl[CTRL_HOLDOFF_BIT];
        cfg_delay   <= ctrl[CTRL_DELAY_LSB +: 4];
        cfg_wait    <= ctrl[CTRL_WAIT_LSB +: 4];
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger pin
  // ----------------------------------------------------------------
  // two-stage synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= trigger_input_pin;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  assign trig_match  = cfg_edge ? (trig_prev && !trig_sync) : (!trig_prev && trig_sync);
  assign trig_active = cfg_edge ? !trig_sync : trig_sync;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Arms (external trigger only), delays and rearms if the trigger is then inactive; then a conversion per sample and a wait between samples.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= ST_IDLE;
      timer        <= 24'h000000;
      remaining    <= 9'h000;
      trigger_seen <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_cycle) begin
            remaining <= 9'(9'h001 << count_shift(ctrl[CTRL_COUNT_LSB +: 3]));
            timer     <= delay_cycles(ctrl[CTRL_DELAY_LSB +: 4]);
            state     <= ctrl[CTRL_EXT_TRIG_BIT] ? ST_ARM : ST_DELAY;
          end
        end
        ST_ARM: begin
          if (trig_match) begin
            timer <= delay_cycles(cfg_delay);
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (timer != 24'h000000) begin
            timer <= timer - 24'h000001;
          end else if (!cfg_ext || trig_active) begin
            state <= ST_START;
          end else begin
            state <= ST_ARM;
          end
        end
        ST_START: begin
          state <= ST_CONVERT;
        end
        ST_CONVERT: begin
          if (conv_done) begin
            remaining    <= remaining - 9'h001;
            trigger_seen <= 1'b0;
            timer        <= wait_cycles(cfg_wait);
            state        <= (remaining == 9'h001) ? ST_FINISH : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (trig_match) begin
            trigger_seen <= 1'b1;
          end
          if (timer != 24'h000000) begin
            timer <= timer - 24'h000001;
          end else if (!(cfg_ext && cfg_holdoff)) begin
            state <= ST_START;
          end else if ((trigger_seen || trig_match) && trig_active) begin
            state <= ST_START;
          end
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Converter controls come from flops; the mux follows the held channel while busy and the control register otherwise.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_start       <= 1'b0;
      mux_select       <= 3'h0;
      ref_ext_select   <= 1'b0;
      ref_regulator_en <= 1'b1;
    end else begin
      conv_start       <= (state == ST_DELAY && timer == 24'h000000 && (!cfg_ext || trig_active)) ||
                          (state == ST_WAIT && timer == 24'h000000 &&
                           (!(cfg_ext && cfg_holdoff) || ((trigger_seen || trig_match) && trig_active)));
      mux_select       <= cycle_busy ? cfg_channel : ctrl[CTRL_CHANNEL_LSB +: 3];
      ref_ext_select   <= cycle_busy ? cfg_ref_ext : ctrl[CTRL_REF_EXT_BIT];
      ref_regulator_en <= cycle_busy ? !cfg_ref_ext : !ctrl[CTRL_REF_EXT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic unit
  // ----------------------------------------------------------------
  // all statistics every sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_sample <= 1'b0;
      sum          <= 18'h00000;
      min_val      <= 10'h000;
      max_val      <= 10'h000;
      last_val     <= 10'h000;
    end else if (start_cycle) begin
      first_sample <= 1'b1;
    end else if (state == ST_CONVERT && conv_done) begin
      first_sample <= 1'b0;
      last_val     <= conv_data;
      if (first_sample) begin
        sum     <= {8'h00, conv_data};
        min_val <= conv_data;
        max_val <= conv_data;
      end else begin
        sum     <= sum + {8'h00, conv_data};
        min_val <= (conv_data < min_val) ? conv_data : min_val;
        max_val <= (conv_data > max_val) ? conv_data : max_val;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_avg  <= 11'h000;
      res_min  <= 11'h000;
      res_max  <= 11'h000;
      res_last <= 11'h000;
    end else if (state == ST_FINISH) begin
      res_avg  <= 11'(sum >> count_shift(cfg_count));
      res_min  <= {1'b0, min_val};
      res_max  <= {1'b0, max_val};
      res_last <= {1'b0, last_val};
    end
  end

  always_comb begin
    case (scs_select_t'(result_select))
      SEL_AVERAGE: accumulator = res_avg;
      SEL_MINIMUM: accumulator = res_min;
      SEL_MAXIMUM: accumulator = res_max;
      default:     accumulator = res_last;
    endcase
  end

  // ----------------------------------------------------------------
  // Status and interrupt pin
  // ----------------------------------------------------------------
  // status low ends cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_busy <= 1'b0;
      int_n      <= 1'b1;
    end else if (start_cycle) begin
      cycle_busy <= 1'b1;
      int_n      <= 1'b1;
    end else if (state == ST_FINISH) begin
      cycle_busy <= 1'b0;
      int_n      <= int_mask;
    end
  end

endmodule

/* File: test/scs_conv_model.sv */
// Behavioural converter engine answering each start after a short or long latency.
module scs_conv_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       conv_start,
  input  wire logic       slow,
  output logic [9:0]      conv_data,
  output logic            conv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] VALS [4] = '{10'h0C8, 10'h3FF, 10'h001, 10'h104};
  logic [1:0] idx;
  int         cnt;

  // Counts the conversion time; data is only meaningful with done, else it toggles.
  always_ff @(posedge aclk) begin
    conv_done <= 1'b0;
    if (!aresetn) begin
      idx <= 2'h0;
      cnt <= 0;
      conv_data <= 10'h000;
    end else if (conv_start) begin
      cnt <= slow ? 9 : 2;
    end else if (cnt == 1) begin
      cnt <= 0;
      conv_done <= 1'b1;
      conv_data <= VALS[idx];
      idx <= idx + 2'h1;
    end else begin
      cnt <= (cnt > 0) ? cnt - 1 : 0;
      conv_data <= ~conv_data;
    end
  end
endmodule

/* File: test/scs_props.sv */
// Port-level checker for the converter sequencer.
module scs_props #(
  parameter int CYCLES_PER_US = 50
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        conv_done,
  input wire logic        conv_start,
  input wire logic [2:0]  mux_select,
  input wire logic        ref_ext_select,
  input wire logic        ref_regulator_en,
  input wire logic        int_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_regulator_off_ext: assert property (ref_regulator_en == !ref_ext_select)
    else $error("Regulator enable does not oppose the reference choice.");
  a_start_single_pulse: assert property (conv_start |=> !conv_start [*2])
    else $error("Conversion start lasted more than one cycle.");
  a_start_irq_high: assert property (conv_start |-> int_n)
    else $error("A conversion started while the interrupt was still low.");
  a_config_held: assert property (conv_start |=> ($stable(mux_select) && $stable(ref_ext_select)) [*2])
    else $error("Channel or reference changed during a conversion.");
  a_wait_gap: assert property (conv_done |=> !conv_start [*8])
    else $error("Next conversion started before the wait time.");
  a_done_quiet: assert property ($fell(int_n) |=> !conv_start [*8])
    else $error("A conversion started right after the cycle ended.");
  a_cycle_on_write: assert property ($rose(int_n) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("A cycle began without a preceding register write.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data did not follow the accepted address.");

  // Main scenarios reached.
  c_cycle_end: cover property ($fell(int_n));
  c_conversion: cover property (conv_start);
  c_write_okay: cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
endmodule

bind scs_sequencer scs_props #(.CYCLES_PER_US(CYCLES_PER_US)) props_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .conv_done(conv_done), .conv_start(conv_start), .mux_select(mux_select),
  .ref_ext_select(ref_ext_select), .ref_regulator_en(ref_regulator_en), .int_n(int_n)
);

/* File: test/scs_sequencer_tb.sv */
// Self-checking testbench for the converter sequencer.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module scs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scs_pkg::*;
  logic        aclk, aresetn, trig, slow, conv_done, conv_start, int_n;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ref_ext_select, ref_regulator_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  mux_select;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [9:0]  conv_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, h, l;
  int          bad_count, n_compared, n_starts, cyc, k;

  scs_sequencer #(.CYCLES_PER_US(1)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .trigger_input_pin(trig), .conv_data(conv_data), .conv_done(conv_done),
    .conv_start(conv_start), .mux_select(mux_select), .ref_ext_select(ref_ext_select),
    .ref_regulator_en(ref_regulator_en), .int_n(int_n)
  );

  scs_conv_model conv_u (
    .aclk(aclk), .aresetn(aresetn), .conv_start(conv_start), .slow(slow),
    .conv_data(conv_data), .conv_done(conv_done)
  );

  // ----------------------------------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // Selects one result, then reads both halves and compares the 11-bit value.
  task automatic res(input logic [1:0] s, input logic [10:0] e);
    wr(ADDR_RESULT_HIGH, 32'(s) << RES_SELECT_LSB);
    rd(ADDR_RESULT_HIGH, h);
    rd(ADDR_RESULT_LOW, l);
    `CHK({h[2:0], l[7:0]}, e)
  endtask

  task automatic wait_done();
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 3000 && int_n !== 1'b0; i++) @(posedge aclk);
    `CHK(int_n, 1'b0)
  endtask

  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Clock, start counter and hang guard.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    n_starts += int'(conv_start);
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, trig, slow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, h);
    `CHK(h, 32'h0)
    rd(ADDR_MASK, h);
    `CHK(h[0], MASK_RESET)
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL, (c << CTRL_CHANNEL_LSB) | ((c & 1) << CTRL_REF_EXT_BIT));
      repeat (2) @(posedge aclk);
      `CHK(mux_select, 3'(c))
      `CHK(ref_regulator_en, ~1'(c))
    end
    wr(ADDR_MASK, 32'h0);
    // Single sample, internal trigger.
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h1 | (32'h3 << CTRL_CHANNEL_LSB));
    wait_done();
    `CHK(int_n, 1'b0)
    for (int s = 0; s < 4; s++) res(2'(s), 11'h0C8);
    // Four samples, internal trigger, with writes while busy.
    wr(ADDR_CTRL, 32'h0);
    k = n_starts;
    wr(ADDR_CTRL, 32'h1 | (32'h1 << CTRL_COUNT_LSB) | (32'h3 << CTRL_CHANNEL_LSB));
    rd(ADDR_RESULT_HIGH, h);
    `CHK(h[RES_STATUS_BIT], 1'b1)
    // The select stands at 3 here; a busy write of 1 must not take.
    wr(ADDR_RESULT_HIGH, 32'h1 << RES_SELECT_LSB);
    wr(ADDR_CTRL, 32'h1 | (32'h7 << CTRL_CHANNEL_LSB));
    repeat (2) @(posedge aclk);
    `CHK(mux_select, 3'h3)
    wait_done();
    `CHK(n_starts - k, 4)
    rd(ADDR_RESULT_HIGH, h);
    `CHK(h[6:5], 2'h3)
    res(2'h0, 11'h173);
    res(2'h1, 11'h001);
    res(2'h2, 11'h3FF);
    res(2'h3, 11'h0C8);
    // Four samples on a rising trigger edge, slow converter.
    wr(ADDR_CTRL, 32'h0);
    slow <= 1'b1;
    k = n_starts;
    wr(ADDR_CTRL, 32'h1 | (32'h1 << CTRL_COUNT_LSB) | (32'h1 << CTRL_EXT_TRIG_BIT));
    repeat (100) @(posedge aclk);
    `CHK(int_n, 1'b1)
    `CHK(n_starts - k, 0)
    trig <= 1'b1;
    repeat (20) @(posedge aclk);
    trig <= 1'b0;
    wait_done();
    `CHK(n_starts - k, 4)
    res(2'h0, 11'h173);
    // One sample on a falling edge with delay; a short pulse must not start it.
    wr(ADDR_CTRL, 32'h0);
    trig <= 1'b1;
    k = n_starts;
    wr(ADDR_CTRL, 32'h1 | (32'h3 << CTRL_EXT_TRIG_BIT) | (32'h1 << CTRL_DELAY_LSB));
    repeat (5) @(posedge aclk);
    trig <= 1'b0;
    repeat (10) @(posedge aclk);
    trig <= 1'b1;
    repeat (100) @(posedge aclk);
    `CHK(n_starts - k, 0)
    trig <= 1'b0;
    wait_done();
    `CHK(n_starts - k, 1)
    res(2'h3, 11'h3FF);
    // Four samples with hold-off: each later sample needs its own rising edge.
    wr(ADDR_CTRL, 32'h0);
    k = n_starts;
    wr(ADDR_CTRL, 32'h1 | (32'h1 << CTRL_COUNT_LSB) | (32'h5 << CTRL_EXT_TRIG_BIT));
    for (int p = 0; p < 4; p++) begin
      trig <= 1'b1;
      repeat (60) @(posedge aclk);
      trig <= 1'b0;
      repeat (10) @(posedge aclk);
      if (p == 0) `CHK(n_starts - k, 1)
    end
    wait_done();
    `CHK(n_starts - k, 4)
    res(2'h2, 11'h3FF);
    results();
  end
endmodule
